/* src/datr_top.sv */
// Dual tracking readout: two channels, select, settle timer and three-state bus.
// Assumes select, enable and target angles come from outside the clock domain.
`timescale 1ns/1ps
module datr_top import datr_pkg::*; #(
    parameter int W = ANGLE_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Transducer angles
    input wire logic [W-1:0] shaft_angle_a,
    input wire logic [W-1:0] shaft_angle_b,
    // Host control
    input wire logic chan_sel,
    input wire logic out_en_n,
    // Shared data bus, index W-1 is bit 1
    output datr_bus_type angle_word_bits,
    // Status
    output logic data_valid,
    output logic fault_n
);
    if (W != ANGLE_W) begin : g_width_chk
        $error("datr_top: width must equal ANGLE_W");
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] sel_sync_ff;
    logic [1:0] oe_sync_ff;
    logic [W-1:0] ang_a_s1_ff, ang_a_s2_ff, ang_b_s1_ff, ang_b_s2_ff;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_sync_ff <= '0;
            oe_sync_ff <= 2'b11;
        end else begin
            sel_sync_ff <= {sel_sync_ff[0], chan_sel};
            oe_sync_ff <= {oe_sync_ff[0], out_en_n};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ang_a_s1_ff <= ANGLE_RST;
            ang_a_s2_ff <= ANGLE_RST;
            ang_b_s1_ff <= ANGLE_RST;
            ang_b_s2_ff <= ANGLE_RST;
        end else begin
            ang_a_s1_ff <= shaft_angle_a;
            ang_a_s2_ff <= ang_a_s1_ff;
            ang_b_s1_ff <= shaft_angle_b;
            ang_b_s2_ff <= ang_b_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels run independently
    datr_chan_type chan_a, chan_b;

    datr_channel #(.W(W)) u_chan_a (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .target_angle(ang_a_s2_ff),
        .chan_out(chan_a)
    );

    datr_channel #(.W(W)) u_chan_b (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .target_angle(ang_b_s2_ff),
        .chan_out(chan_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // Selection and settle timer
    logic sel_q_ff;
    logic oe_n_q_ff;
    logic [SETTLE_W-1:0] settle_ff;
    datr_state_type state_ff;
    logic [W-1:0] data_ff;
    logic fault_n_ff;
    datr_chan_type chosen;

    assign chosen = (sel_sync_ff[1] == SEL_CHAN_A) ? chan_a : chan_b;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_q_ff <= 1'b0;
            oe_n_q_ff <= 1'b1;
        end else begin
            sel_q_ff <= sel_sync_ff[1];
            oe_n_q_ff <= oe_sync_ff[1];
        end
    end

    // Bus drive state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= DATR_FLOAT;
        end else begin
            unique case (state_ff)
                DATR_FLOAT: begin
                    if (!oe_sync_ff[1]) state_ff <= DATR_DRIVE;
                end
                DATR_DRIVE: begin
                    if (oe_sync_ff[1]) state_ff <= DATR_FLOAT;
                end
            endcase
        end
    end

    // Restart settle on select change or enable fall
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            settle_ff <= SETTLE_CNT;
        end else if (sel_q_ff != sel_sync_ff[1]) begin
            settle_ff <= SETTLE_CNT;
        end else if (oe_n_q_ff && !oe_sync_ff[1]) begin
            settle_ff <= SETTLE_CNT;
        end else if (settle_ff != '0) begin
            settle_ff <= settle_ff - 1'b1;
        end
    end

    // Transparent latch: follows selected counter every cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            data_ff <= ANGLE_RST;
            fault_n_ff <= 1'b1;
        end else begin
            data_ff <= chosen.angle;
            fault_n_ff <= ~chosen.fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign angle_word_bits.data = data_ff;
    assign angle_word_bits.oe = {W{state_ff == DATR_DRIVE}};
    assign data_valid = (state_ff == DATR_DRIVE) && (settle_ff == '0);
    assign fault_n = fault_n_ff;
endmodule

/* src/datr_pkg.sv */
// Constants and carrier types for the dual angle tracking readout.
// Assumes a single 100 MHz system clock and synchronous active-low reset.
// Function
// - Each channel tracks shaft angle continuously, one LSB per step, four LSB per step above 55 LSB error, no command.
// - Both channels run identically and independently, sharing one output bus.
// - Select high picks channel A, select low picks channel B.
// - Valid data for the newly selected channel within 640 ns of select change; data_valid rises 650 to 660 ns after the change.
// - Output enable is active low; high floats all 14 data outputs.
// - Valid angle data driven within 640 ns of output enable falling; data_valid rises 650 to 660 ns after the fall.
// - Bus carries angle as binary fraction of a turn, top bit 180 degrees.
// - Output word bit 1 is most significant, bit 14 least significant.
// - Counter steps by error sign and size in closed loop until error nulled.
// - Active-low fault for selected channel sets above 55 LSB, clears below 45.
package datr_pkg;
    localparam int ANGLE_W = 14;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DATA_VALID_NS = 640;
    localparam int FLOAT_NS = 200;
    localparam int DATA_VALID_CYC = DATA_VALID_NS / CLK_PERIOD_NS;
    localparam int FLOAT_CYC = FLOAT_NS / CLK_PERIOD_NS;
    localparam int FAULT_SET_LSB = 55;
    localparam int FAULT_CLR_LSB = 45;
    localparam int SETTLE_W = 7;
    localparam logic [SETTLE_W-1:0] SETTLE_CNT = SETTLE_W'(DATA_VALID_CYC - 1);
    localparam logic [ANGLE_W-1:0] ANGLE_RST = 14'h0000;
    localparam logic SEL_CHAN_A = 1'b1;

    typedef struct packed {
        logic [ANGLE_W-1:0] angle;
        logic fault;
    } datr_chan_type;

    typedef struct packed {
        logic [ANGLE_W-1:0] data;
        logic [ANGLE_W-1:0] oe;
    } datr_bus_type;

    typedef enum logic [1:0] {
        DATR_FLOAT = 2'b01,
        DATR_DRIVE = 2'b10
    } datr_state_type;
endpackage

/* src/datr_channel.sv */
// One tracking channel: closed-loop up/down position counter with fault hysteresis.
// Assumes the target angle arrives synchronised to sys_clk.
`timescale 1ns/1ps
module datr_channel import datr_pkg::*; #(
    parameter int W = ANGLE_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Target shaft angle
    input wire logic [W-1:0] target_angle,
    // Result
    output datr_chan_type chan_out
);
    if (W != ANGLE_W) begin : g_width_chk
        $error("datr_channel: width must equal ANGLE_W");
    end

    logic [W-1:0] pos_ff;
    logic fault_ff;
    logic [W-1:0] err_raw;
    logic [W-1:0] err_mag;
    logic err_neg;
    logic [W-1:0] step;

    // Signed shortest-path error, modulo a turn
    always_comb begin
        err_raw = target_angle - pos_ff;
        err_neg = err_raw[W-1];
        err_mag = err_neg ? W'(~err_raw + 1'b1) : err_raw;
        step = (err_mag > W'(FAULT_SET_LSB)) ? W'(4) : W'(1);
        if (err_mag == '0) begin
            step = '0;
        end
    end

    // Up/down counter nulls error, wraps freely
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pos_ff <= ANGLE_RST;
        end else if (err_neg) begin
            pos_ff <= pos_ff - step;
        end else begin
            pos_ff <= pos_ff + step;
        end
    end

    // Fault flag with hysteresis
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fault_ff <= 1'b0;
        end else if (err_mag > W'(FAULT_SET_LSB)) begin
            fault_ff <= 1'b1;
        end else if (err_mag < W'(FAULT_CLR_LSB)) begin
            fault_ff <= 1'b0;
        end
    end

    assign chan_out.angle = pos_ff;
    assign chan_out.fault = fault_ff;
endmodule

/* tb/datr_checker.sv */
// Port checker for the dual angle tracking readout.
// Bound to datr_top; single clock, synchronous reset.
`timescale 1ns/1ps
module datr_checker import datr_pkg::*; #(
    parameter int W = ANGLE_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic chan_sel,
    input wire logic out_en_n,
    input datr_bus_type angle_word_bits,
    input wire logic data_valid,
    input wire logic fault_n
);
    wire logic [W-1:0] oe = angle_word_bits.oe;
    wire logic [W-1:0] dat = angle_word_bits.data;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    a_oe_uniform: assert property (oe == '0 || oe == '1)
        else $error("oe bits differ");
    a_float_off: assert property (out_en_n [*4] |=> oe == '0)
        else $error("bus not floated");
    a_drive_on: assert property (!out_en_n [*5] |=> oe == '1)
        else $error("bus not driven");
    a_valid_needs_oe: assert property (data_valid |-> oe == '1 && !$past(out_en_n, 3))
        else $error("valid while floated");
    a_settle_early: assert property ($rose(data_valid) |-> !$past(out_en_n, 60))
        else $error("valid too early");
    a_valid_in_time: assert property ($fell(out_en_n) ##1 !out_en_n [*8] |-> ##[1:70] data_valid)
        else $error("valid too late");
    a_step_small: assert property (data_valid && $past(data_valid, 2)
        |-> W'(dat - $past(dat) + W'(4)) <= W'(8))
        else $error("step too large");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> fault_n && oe == '0)
        else $error("reset state wrong");
    a_fault_holds: assert property ($fell(fault_n) |=> !fault_n [*2])
        else $error("fault flickers");
    c_read_a: cover property (data_valid && chan_sel);
    c_read_b: cover property (data_valid && !chan_sel);
    c_fault: cover property ($fell(fault_n));
endmodule
////////////////////////////////////////////////////////////////
bind datr_top datr_checker #(.W(W)) chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .chan_sel(chan_sel), .out_en_n(out_en_n), .angle_word_bits(angle_word_bits),
    .data_valid(data_valid), .fault_n(fault_n));

/* tb/datr_host_model.sv */
// Host processor model reading the shared angle bus.
// Expects go as a one-cycle level from the bench.
`timescale 1ns/1ps
module datr_host_model import datr_pkg::*; (
    // Clock and request
    input wire logic sys_clk,
    input wire logic go,
    input wire logic want_sel,
    input wire logic [3:0] slow,
    // Device side
    input datr_bus_type angle_word_bits,
    input wire logic data_valid,
    output logic chan_sel,
    output logic out_en_n,
    // Result
    output logic [ANGLE_W-1:0] word,
    output logic got
);
    initial begin
        chan_sel = 1'b1;
        out_en_n = 1'b1;
        got = 1'b0;
        forever begin
            @(posedge sys_clk);
            got <= 1'b0;
            if (go) begin
                chan_sel <= want_sel;
                out_en_n <= 1'b0;
                repeat (DATA_VALID_CYC + 2 + slow) @(posedge sys_clk);
                for (int n = 0; n < 200 && !data_valid; n++) @(posedge sys_clk);
                word <= ~(angle_word_bits.data ^ angle_word_bits.oe);
                got <= 1'b1;
                out_en_n <= 1'b1;
                repeat (FLOAT_CYC) @(posedge sys_clk);
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the dual angle tracking readout.
// Host model performs reads; bench sets shaft angles.
`timescale 1ns/1ps
module tb_top import datr_pkg::*;;
    logic sys_clk, rst_n, chan_sel, out_en_n, go, want_sel, got, data_valid, fault_n;
    logic [13:0] a, b, word, w;
    logic [3:0] slow;
    datr_bus_type angle_word_bits;
    logic [13:0] q[$];
    int bad_count, comparisons, seed, cyc;
    datr_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .shaft_angle_a(a), .shaft_angle_b(b),
        .chan_sel(chan_sel), .out_en_n(out_en_n), .angle_word_bits(angle_word_bits),
        .data_valid(data_valid), .fault_n(fault_n));
    datr_host_model host (.sys_clk(sys_clk), .go(go), .want_sel(want_sel), .slow(slow),
        .angle_word_bits(angle_word_bits), .data_valid(data_valid), .chan_sel(chan_sel),
        .out_en_n(out_en_n), .word(word), .got(got));
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (!ok) begin
            bad_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic results;
        $display("bad %0d of %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic rd(input logic s, input logic [13:0] e);
        q.push_back(e);
        want_sel = s;
        slow = 4'($random(seed));
        go = 1'b1;
        @(negedge sys_clk);
        go = 1'b0;
        for (int n = 0; n < 300 && !got; n++) @(negedge sys_clk);
        repeat (FLOAT_CYC + 2) @(negedge sys_clk);
        chk(angle_word_bits.oe === '0 && data_valid === 1'b0, "float");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            results();
        end
    end
    always @(posedge got) begin
        #1;
        w = q.pop_front();
        chk(word === w && fault_n === 1'b1 && data_valid === 1'b1, "word");
    end
    initial begin
        seed = 66;
        rst_n = 1'b0;
        go = 1'b0;
        want_sel = 1'b1;
        slow = 4'h0;
        a = 14'h0001;
        b = 14'h0000;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        chk(fault_n === 1'b1 && data_valid === 1'b0, "reset");
        for (int i = 0; i < 8; i++) begin
            if (i > 0) a = 14'($random(seed));
            b = i[0] ? 14'h3fff : 14'($random(seed));
            repeat (2200) @(negedge sys_clk);
            rd(1'b1, a);
            rd(1'b0, b);
            b = b ^ 14'h2000;
            repeat (8) @(negedge sys_clk);
            chk(fault_n === 1'b0, "fault");
            a = a - 14'h0003;
            rd(1'b1, a);
        end
        results();
    end
endmodule
